//--- drvreg_cfg.svh
// Offsets, field positions, reset values and lock patterns of the register bank
// Included by drvreg_top, drvreg_lock, the host model and the testbench; definitions only
`ifndef DRVREG_CFG_SVH
`define DRVREG_CFG_SVH

// ----------------------------------------------------------------------------
// Register addresses (six address bits of the serial frame)
// ----------------------------------------------------------------------------
`define DRVREG_ADDR_W        6
`define DRVREG_ADDR_OSM      6'h09
`define DRVREG_ADDR_CFG      6'h0c
`define DRVREG_ADDR_CLR      6'h0d
`define DRVREG_ADDR_CFG2     6'h28

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DRVREG_CFG_ACT_BIT   7
`define DRVREG_CFG_RST_BIT   6
`define DRVREG_CFG_OPEN_LOAD_DETECT_DISABLE_BIT 5
`define DRVREG_CFG_OCP_BIT   4
`define DRVREG_CFG_PAIR_MSB  3
`define DRVREG_CFG2_LOCK_MSB 7
`define DRVREG_CFG2_LOCK_LSB 5
`define DRVREG_CFG2_OTW_BIT  2
`define DRVREG_CFG2_SR_BIT   0

// ----------------------------------------------------------------------------
// Reset values and lock patterns
// ----------------------------------------------------------------------------
`define DRVREG_OSM_RST       8'h00
`define DRVREG_CFG_RST       8'h00
`define DRVREG_CLR_RST       8'h00
`define DRVREG_CFG2_RST      8'h60
`define DRVREG_LOCK_SET      3'h6
`define DRVREG_LOCK_OPEN     3'h3

`endif

//--- drvreg_host.sv
// Host model: issues decoded register writes and reads to the bank
// Assumes the bank samples requests on the rising edge of i_clk_sys
`timescale 1ns/1ps
`include "drvreg_cfg.svh"

module drvreg_host (
  // Clock
  input  wire logic                      i_clk_sys,
  // Write request
  output logic                           o_wr_en,
  output logic      [`DRVREG_ADDR_W-1:0] o_wr_addr,
  output logic      [7:0]                o_wr_data,
  // Read request and answer
  output logic                           o_rd_en,
  output logic      [`DRVREG_ADDR_W-1:0] o_rd_addr,
  input  wire logic [7:0]                i_rd_data
);
  initial begin
    o_wr_en   = 1'b0;
    o_wr_addr = 6'h00;
    o_wr_data = 8'h00;
    o_rd_en   = 1'b0;
    o_rd_addr = 6'h00;
  end

  // ----------------------------------------------------------------------
  // Bus cycles, one strobe cycle each; idle lines carry inverted values
  // ----------------------------------------------------------------------
  task automatic wr(input logic [`DRVREG_ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr_en   = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_clk_sys);
    o_wr_en   = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask

  task automatic rd(input logic [`DRVREG_ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_rd_en   = 1'b1;
    o_rd_addr = a;
    @(negedge i_clk_sys);
    d         = i_rd_data;
    o_rd_en   = 1'b0;
    o_rd_addr = ~a;
  endtask
endmodule

//--- drvreg_lock.sv
// Lock keeper of the register bank: guards writes to configuration fields
// Fed by drvreg_top through drvreg_lock_if on the same clock
`timescale 1ns/1ps
`include "drvreg_cfg.svh"

module drvreg_lock (
  // Clock and reset
  input  wire logic      i_clk_sys,
  input  wire logic      i_rst,
  // Bank side
  drvreg_lock_if.keeper  lk
);

  drvreg_pkg::drvreg_lock_t state_r;
  drvreg_pkg::drvreg_lock_t state_nxt;

  // --------------------------------------------------------------------------
  // Lock transitions
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      drvreg_pkg::LK_OPEN: begin
        if (lk.wr_lock && lk.lock_data == `DRVREG_LOCK_SET) begin
          state_nxt = drvreg_pkg::LK_SHUT;
        end
      end
      drvreg_pkg::LK_SHUT: begin
        if (lk.wr_lock && lk.lock_data == `DRVREG_LOCK_OPEN) begin
          state_nxt = drvreg_pkg::LK_OPEN;
        end
      end
      default: state_nxt = drvreg_pkg::LK_OPEN;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= drvreg_pkg::LK_OPEN;
    end else if (lk.soft_rst) begin
      state_r <= drvreg_pkg::LK_OPEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign lk.locked = (state_r == drvreg_pkg::LK_SHUT);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_lock_set;
    (!lk.locked && lk.wr_lock && !lk.soft_rst && lk.lock_data == 3'h6) |=> lk.locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock pattern did not lock");

  property p_lock_other;
    (!lk.locked && lk.wr_lock && lk.lock_data != 3'h6) |=> !lk.locked;
  endproperty
  a_lock_other: assert property (p_lock_other) else $error("bad pattern changed lock");

  property p_unlock;
    (lk.locked && lk.wr_lock && !lk.soft_rst)
      |=> (lk.locked == $past(lk.lock_data != 3'h3));
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock pattern misapplied");

endmodule

//--- drvreg_lock_if.sv
// Carrier between the bank and its lock keeper
// Both ends run on the bank clock
`timescale 1ns/1ps

interface drvreg_lock_if;
  logic       wr_lock;
  logic [2:0] lock_data;
  logic       soft_rst;
  logic       locked;

  modport bank (output wr_lock, output lock_data, output soft_rst, input locked);
  modport keeper (input wr_lock, input lock_data, input soft_rst, output locked);
endinterface

//--- drvreg_pkg.sv
// Types shared by the register bank files
// Assumes nothing beyond a SystemVerilog compiler
package drvreg_pkg;

  // --------------------------------------------------------------------------
  // Lock state machine
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    LK_OPEN = 1'b0,
    LK_SHUT = 1'b1
  } drvreg_lock_t;

  // --------------------------------------------------------------------------
  // Decoded register select
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_OSM  = 3'h1,
    SEL_CFG  = 3'h2,
    SEL_CLR  = 3'h3,
    SEL_CFG2 = 3'h4
  } drvreg_sel_t;

endpackage

//--- drvreg_top.sv
// Register bank: status monitor, configuration, latch clear, configuration two
// Assumes frame logic on i_clk_sys delivers decoded writes and reads
//
// What this block does
// - Status bit per channel: one means VDS low
// - Active bit enters or leaves active mode
// - Reset command bit pulses, then self clears
// - Open-load disable bit turns detection off
// - Overcurrent bit picks profile one or two
// - Four pairing bits synchronise channel pair protection
// - Writing one clears that channel's error latch
// - Pattern 110 locks; locked ignores most writes
// - Other patterns leave an unlocked bank unlocked
// - Pattern 011 unlocks; others keep the lock
// - Overtemperature warning flag is read only
// - Slew bit picks slow or fast edges
`timescale 1ns/1ps
`include "drvreg_cfg.svh"

module drvreg_top (
  // Clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  // Register writes from frame logic
  input  wire logic                      i_wr_en,
  input  wire logic [`DRVREG_ADDR_W-1:0] i_wr_addr,
  input  wire logic [7:0]                i_wr_data,
  // Register reads from frame logic
  input  wire logic                      i_rd_en,
  input  wire logic [`DRVREG_ADDR_W-1:0] i_rd_addr,
  output logic      [7:0]                o_rd_data,
  // Analog monitors, asynchronous
  input  wire logic [7:0]                i_vds_low,
  input  wire logic                      i_overtemp_event,
  // Control outputs to the driver core
  output logic                           o_active_mode_request,
  output logic                           o_reset_cmd,
  output logic                           o_open_load_detect_disable,
  output logic                           o_overcurrent_profile_select,
  output logic      [3:0]                o_pair_sync,
  output logic      [7:0]                o_error_latch_clear_bit,
  output logic                           o_slew_select,
  output logic                           o_locked
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic drvreg_pkg::drvreg_sel_t sel_of(input logic [`DRVREG_ADDR_W-1:0] a);
    case (a)
      `DRVREG_ADDR_OSM:  sel_of = drvreg_pkg::SEL_OSM;
      `DRVREG_ADDR_CFG:  sel_of = drvreg_pkg::SEL_CFG;
      `DRVREG_ADDR_CLR:  sel_of = drvreg_pkg::SEL_CLR;
      `DRVREG_ADDR_CFG2: sel_of = drvreg_pkg::SEL_CFG2;
      default:           sel_of = drvreg_pkg::SEL_NONE;
    endcase
  endfunction

  drvreg_lock_if lk_if ();

  logic       rst_cmd_r;
  logic       active_r;
  logic       oldis_r;
  logic       ocp_r;
  logic [3:0] pair_r;
  logic [7:0] clr_r;
  logic [7:0] clr_pulse_r;
  logic       slew_r;
  logic       otw_r;
  logic [7:0] osm_r;
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync3_r;
  logic [7:0] rd_data_r;
  logic       wr_ok;
  logic       wr_cfg;
  logic       wr_clr;
  logic       wr_cfg2;
  logic       locked;
  drvreg_pkg::drvreg_sel_t wr_sel;

  // --------------------------------------------------------------------------
  // Write qualification
  // --------------------------------------------------------------------------
  assign locked  = lk_if.locked;
  assign wr_sel  = sel_of(i_wr_addr);
  assign wr_ok   = i_wr_en && !rst_cmd_r;
  assign wr_cfg  = wr_ok && wr_sel == drvreg_pkg::SEL_CFG && !locked;
  assign wr_clr  = wr_ok && wr_sel == drvreg_pkg::SEL_CLR;
  assign wr_cfg2 = wr_ok && wr_sel == drvreg_pkg::SEL_CFG2;

  assign lk_if.wr_lock   = wr_cfg2;
  assign lk_if.lock_data = i_wr_data[`DRVREG_CFG2_LOCK_MSB:`DRVREG_CFG2_LOCK_LSB];
  assign lk_if.soft_rst  = rst_cmd_r;

  drvreg_lock u_lock (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .lk        (lk_if.keeper)
  );

  // --------------------------------------------------------------------------
  // Reset command, one cycle then gone
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_cmd_r <= 1'b0;
    end else begin
      rst_cmd_r <= wr_cfg && i_wr_data[`DRVREG_CFG_RST_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      active_r <= 1'b0;
      oldis_r  <= 1'b0;
      ocp_r    <= 1'b0;
      pair_r   <= 4'h0;
    end else if (rst_cmd_r) begin
      active_r <= 1'b0;
      oldis_r  <= 1'b0;
      ocp_r    <= 1'b0;
      pair_r   <= 4'h0;
    end else if (wr_cfg) begin
      active_r <= i_wr_data[`DRVREG_CFG_ACT_BIT];
      oldis_r  <= i_wr_data[`DRVREG_CFG_OPEN_LOAD_DETECT_DISABLE_BIT];
      ocp_r    <= i_wr_data[`DRVREG_CFG_OCP_BIT];
      pair_r   <= i_wr_data[`DRVREG_CFG_PAIR_MSB:0];
    end
  end

  // --------------------------------------------------------------------------
  // Latch clear register and clear strobes
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clr_r       <= `DRVREG_CLR_RST;
      clr_pulse_r <= 8'h00;
    end else if (rst_cmd_r) begin
      clr_r       <= `DRVREG_CLR_RST;
      clr_pulse_r <= 8'h00;
    end else if (wr_clr) begin
      clr_r       <= i_wr_data;
      clr_pulse_r <= i_wr_data;
    end else begin
      clr_pulse_r <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration two: slew select
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      slew_r <= 1'b0;
    end else if (rst_cmd_r) begin
      slew_r <= 1'b0;
    end else if (wr_cfg2 && !locked) begin
      slew_r <= i_wr_data[`DRVREG_CFG2_SR_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Monitor synchronisers, change taken when stages two and three agree
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      sync3_r <= 9'h000;
    end else begin
      sync1_r <= {i_overtemp_event, i_vds_low};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      osm_r <= `DRVREG_OSM_RST;
    end else begin
      osm_r <= (sync2_r[7:0] & sync3_r[7:0]) | (osm_r & (sync2_r[7:0] | sync3_r[7:0]));
    end
  end

  // Sticky warning; a new event beats the command clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      otw_r <= 1'b0;
    end else if (sync2_r[8] && sync3_r[8]) begin
      otw_r <= 1'b1;
    end else if (rst_cmd_r) begin
      otw_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read path, registered
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_data_r <= 8'h00;
    end else if (i_rd_en) begin
      case (sel_of(i_rd_addr))
        drvreg_pkg::SEL_OSM:  rd_data_r <= osm_r;
        drvreg_pkg::SEL_CFG:  rd_data_r <= {active_r, rst_cmd_r, oldis_r, ocp_r, pair_r};
        drvreg_pkg::SEL_CLR:  rd_data_r <= clr_r;
        drvreg_pkg::SEL_CFG2: rd_data_r <= {(locked ? `DRVREG_LOCK_SET : `DRVREG_LOCK_OPEN),
                                            2'h0, otw_r, 1'b0, slew_r};
        default:              rd_data_r <= 8'h00;
      endcase
    end
  end

  assign o_rd_data                    = rd_data_r;
  assign o_active_mode_request        = active_r;
  assign o_reset_cmd                  = rst_cmd_r;
  assign o_open_load_detect_disable   = oldis_r;
  assign o_overcurrent_profile_select = ocp_r;
  assign o_pair_sync                  = pair_r;
  assign o_error_latch_clear_bit      = clr_pulse_r;
  assign o_slew_select                = slew_r;
  assign o_locked                     = locked;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_osm_follow;
    (sync2_r[7:0] == sync3_r[7:0]) |=> osm_r == $past(sync3_r[7:0]);
  endproperty
  a_osm_follow: assert property (p_osm_follow) else $error("status bits not tracking");

  property p_active;
    wr_cfg |=> o_active_mode_request == $past(i_wr_data[7]);
  endproperty
  a_active: assert property (p_active) else $error("active bit not loaded");

  sequence s_rst_issue;
    wr_cfg && i_wr_data[6];
  endsequence
  sequence s_rst_done;
    o_reset_cmd ##1 (!o_reset_cmd && !o_active_mode_request && !o_locked
                     && o_pair_sync == 4'h0 && !o_slew_select);
  endsequence
  property p_rst_cmd;
    s_rst_issue |=> s_rst_done;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("reset command misbehaved");

  property p_oldis;
    wr_cfg |=> o_open_load_detect_disable == $past(i_wr_data[5]);
  endproperty
  a_oldis: assert property (p_oldis) else $error("open-load disable not loaded");

  property p_ocp;
    wr_cfg |=> o_overcurrent_profile_select == $past(i_wr_data[4]);
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent profile not loaded");

  property p_pair;
    wr_cfg |=> o_pair_sync == $past(i_wr_data[3:0]);
  endproperty
  a_pair: assert property (p_pair) else $error("pairing bits not loaded");

  property p_clr;
    (i_wr_en && !o_reset_cmd && i_wr_addr == 6'h0d)
      |=> o_error_latch_clear_bit == $past(i_wr_data) ##1 (o_error_latch_clear_bit == 8'h00
          || $past(i_wr_en));
  endproperty
  a_clr: assert property (p_clr) else $error("latch clear strobe wrong");

  property p_locked_hold;
    (o_locked && i_wr_en && i_wr_addr == 6'h0c)
      |=> $stable(o_active_mode_request) && $stable(o_pair_sync) && !o_reset_cmd;
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("write passed the lock");

  property p_otw;
    (sync2_r[8] && sync3_r[8]) |=> otw_r;
  endproperty
  a_otw: assert property (p_otw) else $error("warning flag not set");

  property p_slew;
    (i_wr_en && !o_reset_cmd && !o_locked && i_wr_addr == 6'h28)
      |=> o_slew_select == $past(i_wr_data[0]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew select not loaded");

  property p_soft_default;
    o_reset_cmd |=> !o_active_mode_request && !o_open_load_detect_disable
                    && !o_overcurrent_profile_select && !otw_r == !$past(sync3_r[8] && sync2_r[8]);
  endproperty
  a_soft_default: assert property (p_soft_default) else $error("defaults not restored");

endmodule

//--- tb.sv
// Testbench of the register bank: sequences of host reads and writes
// Assumes drvreg_top, drvreg_lock, drvreg_lock_if and the host model
`timescale 1ns/1ps
`include "drvreg_cfg.svh"

module tb;
  logic                      i_clk_sys;
  logic                      i_rst;
  logic                      wr_en;
  logic [`DRVREG_ADDR_W-1:0] wr_addr;
  logic [7:0]                wr_data;
  logic                      rd_en;
  logic [`DRVREG_ADDR_W-1:0] rd_addr;
  logic [7:0]                rd_data;
  logic [7:0]                i_vds_low;
  logic                      i_overtemp_event;
  logic                      act, rcmd, open_load_detect_disable, overcurrent_profile_select, slew, locked;
  logic [3:0]                pair;
  logic [7:0]                clr;
  int                        n_fail;
  int                        comparisons;
  logic [7:0]                cfg_tab [8];

  drvreg_top dut (
    .i_clk_sys                    (i_clk_sys),
    .i_rst                        (i_rst),
    .i_wr_en                      (wr_en),
    .i_wr_addr                    (wr_addr),
    .i_wr_data                    (wr_data),
    .i_rd_en                      (rd_en),
    .i_rd_addr                    (rd_addr),
    .o_rd_data                    (rd_data),
    .i_vds_low                    (i_vds_low),
    .i_overtemp_event             (i_overtemp_event),
    .o_active_mode_request        (act),
    .o_reset_cmd                  (rcmd),
    .o_open_load_detect_disable   (open_load_detect_disable),
    .o_overcurrent_profile_select (overcurrent_profile_select),
    .o_pair_sync                  (pair),
    .o_error_latch_clear_bit      (clr),
    .o_slew_select                (slew),
    .o_locked                     (locked)
  );

  drvreg_host host (
    .i_clk_sys (i_clk_sys),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------------------------------------
  // Compare, read-compare and verdict
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [`DRVREG_ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_fail           = 0;
    comparisons      = 0;
    i_rst            = 1'b1;
    i_vds_low        = 8'h00;
    i_overtemp_event = 1'b0;
    cfg_tab          = '{8'h80, 8'h20, 8'h10, 8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk({act, rcmd, open_load_detect_disable, overcurrent_profile_select, pair}, 8'h00);
    chk({clr}, 8'h00);
    chk({6'h00, locked, slew}, 8'h00);
    rdchk(`DRVREG_ADDR_OSM, 8'h00);
    rdchk(`DRVREG_ADDR_CFG, 8'h00);
    rdchk(`DRVREG_ADDR_CLR, 8'h00);
    rdchk(`DRVREG_ADDR_CFG2, 8'h60);
    // Status follows the monitor inputs
    i_vds_low = 8'ha5;
    repeat (4) @(negedge i_clk_sys);
    rdchk(`DRVREG_ADDR_OSM, 8'ha5);
    i_vds_low = 8'h3c;
    repeat (4) @(negedge i_clk_sys);
    rdchk(`DRVREG_ADDR_OSM, 8'h3c);
    // Every configuration field alone except the reset command bit
    for (int k = 0; k < 8; k++) begin
      host.wr(`DRVREG_ADDR_CFG, cfg_tab[k]);
      chk({act, 1'b0, open_load_detect_disable, overcurrent_profile_select, pair}, cfg_tab[k]);
      rdchk(`DRVREG_ADDR_CFG, cfg_tab[k]);
    end
    // Slew, and a non-locking pattern
    host.wr(`DRVREG_ADDR_CFG2, 8'h01);
    chk({6'h00, locked, slew}, 8'h01);
    rdchk(`DRVREG_ADDR_CFG2, 8'h61);
    // Overtemperature flag sticks and ignores writes
    i_overtemp_event = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    i_overtemp_event = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    rdchk(`DRVREG_ADDR_CFG2, 8'h65);
    host.wr(`DRVREG_ADDR_CFG2, 8'h01);
    rdchk(`DRVREG_ADDR_CFG2, 8'h65);
    // Lock, refused writes, clear still taken
    host.wr(`DRVREG_ADDR_CFG2, 8'hc0);
    chk({7'h00, locked}, 8'h01);
    rdchk(`DRVREG_ADDR_CFG2, 8'hc4);
    host.wr(`DRVREG_ADDR_CFG, 8'h80);
    chk({7'h00, act}, 8'h00);
    rdchk(`DRVREG_ADDR_CFG, 8'h00);
    host.wr(`DRVREG_ADDR_CFG2, 8'ha1);
    chk({6'h00, locked, slew}, 8'h02);
    rdchk(`DRVREG_ADDR_CFG2, 8'hc4);
    host.wr(`DRVREG_ADDR_CLR, 8'h03);
    chk(clr, 8'h03);
    host.wr(`DRVREG_ADDR_CFG2, 8'h60);
    chk({7'h00, locked}, 8'h00);
    host.wr(`DRVREG_ADDR_CFG2, 8'h61);
    rdchk(`DRVREG_ADDR_CFG2, 8'h65);
    // Latch clear pulses once per write
    host.wr(`DRVREG_ADDR_CLR, 8'h5a);
    chk(clr, 8'h5a);
    @(negedge i_clk_sys);
    chk(clr, 8'h00);
    rdchk(`DRVREG_ADDR_CLR, 8'h5a);
    // Unmapped read and write to the status register
    rdchk(6'h3f, 8'h00);
    host.wr(`DRVREG_ADDR_OSM, 8'hff);
    rdchk(`DRVREG_ADDR_OSM, 8'h3c);
    // Reset command restores defaults and clears itself
    host.wr(`DRVREG_ADDR_CFG, 8'h9f);
    host.wr(`DRVREG_ADDR_CFG, 8'hdf);
    chk({7'h00, rcmd}, 8'h01);
    @(negedge i_clk_sys);
    chk({act, rcmd, open_load_detect_disable, overcurrent_profile_select, pair}, 8'h00);
    chk({6'h00, locked, slew}, 8'h00);
    rdchk(`DRVREG_ADDR_CFG, 8'h00);
    rdchk(`DRVREG_ADDR_CFG2, 8'h60);
    rdchk(`DRVREG_ADDR_CLR, 8'h00);
    print_verdict();
  end
endmodule
